// >>> rtl/csd_regs.vh
// Opcode, field and timing constants for the conditional skip decoder.
`ifndef CSD_REGS_VH
`define CSD_REGS_VH
`define CSD_OP_BIT_BASE 10'h020
`define CSD_OP_BIT_MASK 10'h3FC
`define CSD_OP_FULL_MASK 10'h3FF
`define CSD_OP_CARRY 10'h02F
`define CSD_OP_PIN_FIRST 10'h024
`define CSD_OP_PIN_SECOND 10'h02B
`define CSD_BIT_IDX_LO 0
`define CSD_BIT_IDX_HI 1
`define CSD_PIN_IDX_MAX 4'h4
`define CSD_PORT_W 5
`define CSD_PIN_CYCLES 2
`endif

// >>> rtl/csd_test_sel.v
// Bit selector used by the skip tests.
module csd_test_sel (
  input wire [7:0] data_i,
  input wire [3:0] index_i,
  output wire bit_o
);
  // Picks the indexed bit; indices beyond the word read as one.
  assign bit_o = (index_i < 4'h8) ? data_i[index_i[2:0]] : 1'b1;
endmodule

// >>> rtl/csd_decode.v
// Conditional skip decoder and executor for the small core.
`include "csd_regs.vh"

// What this block does
// RL1: Skip next instruction when memory bit j (0..3) at data_pointer is zero; one cycle.
// RL2: Carry skip is one word, opcode 0x02F, completes in one cycle.
// RL3: Carry skip skips the next instruction when carry_flag is zero.
// RL4: Carry skip never modifies carry_flag.
// RL5: Carry skip executes the next instruction normally when carry_flag is one.
// RL6: Port pin skip is two words, 0x024 then 0x02B, taking two cycles.
// RL7: Port pin skip skips when indexed port bit is zero, executes when one.
// RL8: Program issues port pin skip only with index register 0 through 4.
// RL9: A taken skip turns next instruction into a no-op; program counter advances.
module csd_decode (
  input wire MCLK_I,
  input wire SRST_I,
  input wire INSTR_VALID_I,
  input wire [9:0] INSTR_I,
  input wire [3:0] MEM_DATA_I,
  input wire CARRY_FLAG_I,
  input wire [3:0] INDEX_Y_I,
  input wire [4:0] PORT_OUT_I,
  output reg SKIP_O,
  output reg SUPPRESS_O,
  output reg BUSY_O,
  output reg DONE_O,
  output reg CARRY_FLAG_O
);

  // ****************************************
  // State and decode.
  // ****************************************
  localparam ST_IDLE = 1'b0;
  localparam ST_PIN2 = 1'b1;

  reg state_reg;
  reg state_next;
  reg suppress_reg;
  reg suppress_next;
  reg skip_next;
  reg done_next;
  reg busy_next;
  wire mem_bit;
  wire pin_bit;
  wire mem_zero;
  wire pin_zero;
  wire carry_zero;
  wire pin_index_ok;
  wire [3:0] bit_index;
  wire is_bit_op;
  wire is_carry_op;
  wire is_pin_first;
  wire is_pin_second;
  wire exec_valid;

  function match;
    input [9:0] word;
    input [9:0] code;
    input [9:0] mask;
    begin
      match = ((word ^ code) & mask) == 10'h000;
    end
  endfunction

  function is_word;
    input [9:0] word;
    input [9:0] code;
    begin
      is_word = match(word, code, `CSD_OP_FULL_MASK);
    end
  endfunction

  // ****************************************
  // Operand tests.
  // ****************************************
  // A suppressed instruction decodes to nothing.
  assign exec_valid = INSTR_VALID_I & ~suppress_reg; // RL9
  assign bit_index = {2'b00, INSTR_I[`CSD_BIT_IDX_HI:`CSD_BIT_IDX_LO]}; // RL1
  assign pin_index_ok = (INDEX_Y_I <= `CSD_PIN_IDX_MAX); // RL8
  assign mem_zero = ~mem_bit; // RL1
  assign pin_zero = ~pin_bit; // RL7
  assign carry_zero = ~CARRY_FLAG_I; // RL3

  csd_test_sel u_mem_sel (
    .data_i({4'h0, MEM_DATA_I}),
    .index_i(bit_index),
    .bit_o(mem_bit)
  );

  csd_test_sel u_pin_sel (
    .data_i({3'b000, PORT_OUT_I}),
    .index_i(INDEX_Y_I),
    .bit_o(pin_bit)
  );

  // ****************************************
  // Opcode decode.
  // ****************************************
  // Bit tests and the pin test's first word have separate opcodes.
  assign is_pin_first = exec_valid && (state_reg == ST_IDLE) && pin_index_ok &&
                        is_word(INSTR_I, `CSD_OP_PIN_FIRST); // RL6
  assign is_bit_op = exec_valid && (state_reg == ST_IDLE) &&
                     match(INSTR_I, `CSD_OP_BIT_BASE, `CSD_OP_BIT_MASK); // RL1
  assign is_carry_op = exec_valid && (state_reg == ST_IDLE) &&
                       is_word(INSTR_I, `CSD_OP_CARRY); // RL2
  assign is_pin_second = exec_valid && (state_reg == ST_PIN2) &&
                         is_word(INSTR_I, `CSD_OP_PIN_SECOND); // RL6

  // ****************************************
  // Next state.
  // ****************************************
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (is_pin_first) begin
          state_next = ST_PIN2; // RL6
        end
      end
      ST_PIN2: begin
        if (INSTR_VALID_I) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // ****************************************
  // Skip decision.
  // ****************************************
  always @* begin
    skip_next = 1'b0;
    done_next = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (is_bit_op) begin
          skip_next = mem_zero; // RL1
          done_next = 1'b1;
        end else if (is_carry_op) begin
          skip_next = carry_zero; // RL3 RL5
          done_next = 1'b1; // RL2
        end
      end
      ST_PIN2: begin
        if (is_pin_second) begin
          skip_next = pin_zero; // RL7
          done_next = 1'b1; // RL6
        end
      end
      default: begin
        skip_next = 1'b0;
      end
    endcase
  end

  // ****************************************
  // Suppression and wait flags.
  // ****************************************
  always @* begin
    suppress_next = suppress_reg;
    if (INSTR_VALID_I) begin
      suppress_next = skip_next; // RL9
    end
    busy_next = (state_next == ST_PIN2); // RL6
  end

  // ****************************************
  // State registers.
  // ****************************************
  always @(posedge MCLK_I) begin
    if (SRST_I) begin
      state_reg <= ST_IDLE;
      suppress_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      suppress_reg <= suppress_next; // RL9
    end
  end

  // ****************************************
  // Output registers.
  // ****************************************
  always @(posedge MCLK_I) begin
    if (SRST_I) begin
      SKIP_O <= 1'b0;
    end else begin
      SKIP_O <= skip_next; // RL1 RL3 RL7
    end
  end

  always @(posedge MCLK_I) begin
    if (SRST_I) begin
      DONE_O <= 1'b0;
    end else begin
      DONE_O <= done_next;
    end
  end

  always @(posedge MCLK_I) begin
    if (SRST_I) begin
      SUPPRESS_O <= 1'b0;
    end else begin
      SUPPRESS_O <= suppress_next; // RL9
    end
  end

  always @(posedge MCLK_I) begin
    if (SRST_I) begin
      BUSY_O <= 1'b0;
    end else begin
      BUSY_O <= busy_next; // RL6
    end
  end

  // Carry passes through untouched, skip or not.
  always @(posedge MCLK_I) begin
    if (SRST_I) begin
      CARRY_FLAG_O <= 1'b0;
    end else begin
      CARRY_FLAG_O <= CARRY_FLAG_I; // RL4
    end
  end

endmodule

// >>> verification/csd_fetch.sv
// Fetch model handing program words to the decoder.
module csd_fetch (
  input wire clk_i,
  input wire go_i,
  input wire [9:0] word_i,
  output reg valid_o = 1'b0,
  output reg [9:0] instr_o = 10'h000
);
  timeunit 1ns;
  timeprecision 1ns;
  always @(negedge clk_i) begin
    valid_o <= go_i;
    instr_o <= go_i ? word_i : ~instr_o;
  end
endmodule

// >>> verification/csd_decode_checker.sv
// Assertions on the decoder ports.
module csd_decode_checker (input wire MCLK_I, input wire SRST_I, input wire INSTR_VALID_I,
  input wire [9:0] INSTR_I, input wire [3:0] MEM_DATA_I, input wire CARRY_FLAG_I,
  input wire [3:0] INDEX_Y_I, input wire [4:0] PORT_OUT_I, input wire SKIP_O,
  input wire SUPPRESS_O, input wire BUSY_O, input wire DONE_O, input wire CARRY_FLAG_O);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (SRST_I);
  wire go = INSTR_VALID_I && !SUPPRESS_O && !BUSY_O;
  wire cz = go && INSTR_I == 10'h02F;
  wire pn = BUSY_O && INSTR_VALID_I && INSTR_I == 10'h02B;
  carry_skip_a: assert property (cz && !CARRY_FLAG_I |=> SKIP_O && DONE_O) else $error("c0");
  carry_run_a: assert property (cz && CARRY_FLAG_I |=> DONE_O && !SKIP_O) else $error("c1");
  carry_keep_a: assert property (!$past(SRST_I) |-> CARRY_FLAG_O == $past(CARRY_FLAG_I))
    else $error("cy");
  pin_wait_a: assert property (go && INSTR_I == 10'h024 && INDEX_Y_I <= 4'h4 |=> BUSY_O
    && !DONE_O) else $error("pw");
  pin_skip_a: assert property (pn && !PORT_OUT_I[INDEX_Y_I] |=> SKIP_O && DONE_O)
    else $error("p0");
  pin_run_a: assert property (pn && PORT_OUT_I[INDEX_Y_I] |=> DONE_O && !SKIP_O)
    else $error("p1");
  bit_skip_a: assert property (go && INSTR_I[9:2] == 8'h08 &&
    !MEM_DATA_I[INSTR_I[1:0]] |=> SKIP_O && DONE_O) else $error("b0");
  skip_mask_a: assert property (SUPPRESS_O && INSTR_VALID_I |=> !DONE_O && !SUPPRESS_O)
    else $error("sm");
endmodule
bind csd_decode csd_decode_checker chk_i (.*);

// >>> verification/csd_decode_bench.sv
// Self-checking bench for the skip decoder.
module csd_decode_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, go = 1'b0, cy = 1'b0, valid, skip, sup, busy, done, cyo;
  logic [9:0] wd = 10'h000, instr;
  logic [3:0] mem = 4'h0, y = 4'h0;
  logic [4:0] port = 5'h00;
  int failures = 0, compares = 0;
  csd_fetch FETCH (.clk_i(clk), .go_i(go), .word_i(wd), .valid_o(valid), .instr_o(instr));
  csd_decode DUT (.MCLK_I(clk), .SRST_I(rst), .INSTR_VALID_I(valid), .INSTR_I(instr),
    .MEM_DATA_I(mem), .CARRY_FLAG_I(cy), .INDEX_Y_I(y), .PORT_OUT_I(port), .SKIP_O(skip),
    .SUPPRESS_O(sup), .BUSY_O(busy), .DONE_O(done), .CARRY_FLAG_O(cyo));
  initial begin
    forever #25 clk = ~clk;
  end
  task chk(input logic g, input logic e);
    compares++;
    if (g !== e) begin
      failures++;
      $display("Error %0t: output mismatch", $time);
    end
  endtask
  task tally_and_finish;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task step(input logic g, input logic [9:0] w);
    @(posedge clk);
    go = g;
    wd = w;
    @(negedge clk);
  endtask
  task fin(input string s);
    step(1'b1, 10'h000);
    $display("%s test done", s);
  endtask
  task t_bit(input int j, input logic b);
    y = 4'h5;
    mem = b ? 4'h1 << j : ~(4'h1 << j);
    step(1'b1, 10'h020 + j[9:0]);
    step(1'b0, 10'h000);
    chk(skip, !b);
    chk(done, 1'b1);
    chk(sup, !b);
    fin("bit");
  endtask
  task t_pin(input int k, input logic b);
    y = k[3:0];
    port = b ? 5'h01 << k : ~(5'h01 << k);
    step(1'b1, 10'h024);
    step(1'b1, 10'h02B);
    chk(busy, 1'b1);
    step(1'b0, 10'h000);
    chk(skip, !b);
    chk(done, 1'b1);
    chk(sup, !b);
    fin("pin");
  endtask
  task t_carry(input logic c);
    cy = c;
    step(1'b1, 10'h02F);
    step(1'b1, 10'h02F);
    chk(skip, !c);
    chk(done, 1'b1);
    step(1'b0, 10'h000);
    chk(done, c);
    chk(cyo, c);
    fin("carry");
  endtask
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    for (int j = 0; j < 4; j++) for (int b = 0; b < 2; b++) t_bit(j, b[0]);
    for (int k = 0; k < 5; k++) for (int b = 0; b < 2; b++) t_pin(k, b[0]);
    t_carry(1'b0);
    t_carry(1'b1);
    tally_and_finish;
  end
  initial begin
    #20000;
    failures++;
    tally_and_finish;
  end
endmodule
